// >>> core/wsdc_counter.sv
// weld-step down-counter with apb registers and front-panel inputs
//
// Register access over APB and the placing of the registers were decided locally.
`include "wsdc_defines.svh"

module wsdc_counter
  import wsdc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic prog_mode,
  input wire logic btn_enter,
  input wire logic btn_data1,
  input wire logic btn_data10,
  input wire logic btn_other,
  input wire logic estop,
  input wire logic ext_reset_nc,
  input wire logic weld_done,
  input wire logic seq_end,
  output logic [13:0] disp_data,
  output logic [3:0] disp_step,
  output logic disp_valid,
  output logic end_flash,
  output logic po_valve,
  output logic valve3,
  output logic irq
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // ctrl: [1:0] seq sel, [7:2] base schedule, [15:8] ext fn,
  // [17:16] process output sel, [18] show count, [23:19] last step
  logic [31:0] ctrl_reg, ctrl_next;
  // per-step count and off time
  logic [13:0] step_cnt_reg [`WSDC_NUM_STEPS];
  logic [6:0] step_off_reg [`WSDC_NUM_STEPS];
  logic [13:0] cnt_reg, cnt_next;
  logic [3:0] step_reg, step_next;
  wsdc_state_e st_reg, st_next;
  logic [7:0] show_reg, show_next;
  logic [`WSDC_IRQ_BITS-1:0] ist_reg, ist_next;
  logic [`WSDC_IRQ_BITS-1:0] imask_reg, imask_next;
  logic [13:0] disp_reg, disp_next;
  logic [3:0] dstep_reg, dstep_next;
  logic dval_reg, dval_next;
  logic [13:0] step_cnt_next [`WSDC_NUM_STEPS];
  logic [6:0] step_off_next [`WSDC_NUM_STEPS];
  logic ext_q_reg, ext_q_next;
  logic btn_q_reg, btn_q_next;
  logic hit_ctrl, hit_cfg, hit_wr, hit_stat, hit_ist, hit_imask;
  logic [3:0] nxt_idx;
  logic next_empty;

  logic wr, rd_ok, addr_ok;
  logic [1:0] sel;
  logic [5:0] base;
  // all five bits kept: with bit 23 set the last step is never reached
  logic [4:0] last_step;
  logic active, all3, any_btn, btn_rise, ext_open, do_reset;
  logic step_wr;
  logic [3:0] wr_idx;
  logic [13:0] wr_cnt;
  logic [6:0] wr_off;
  logic [`WSDC_IRQ_BITS-1:0] ev;

  assign wr = psel && penable && pwrite;
  assign pready = 1'b1;
  assign sel = ctrl_reg[1:0];
  assign base = ctrl_reg[7:2];
  assign last_step = ctrl_reg[23:19];
  // the index wraps, so step 15 looks at step 0 as its follower
  assign nxt_idx = step_reg + 4'h1;
  // empty follower: no count and the off time WSDC_EMPTY_OFF
  assign next_empty = (step_cnt_reg[nxt_idx] == 14'h0)
    && (step_off_reg[nxt_idx] == `WSDC_EMPTY_OFF);
  assign addr_ok = (base == 6'd0) || (base == 6'd10) || (base == 6'd20)
    || (base == 6'd30) || (base == 6'd40);
  assign active = ((sel == `WSDC_SEQ_A) || (sel == `WSDC_SEQ_B)) && addr_ok;
  assign all3 = btn_enter && btn_data1 && btn_data10;
  assign any_btn = btn_enter || btn_data1 || btn_data10 || btn_other;
  assign btn_rise = any_btn && !btn_q_reg;
  // open edge of the closed switch
  assign ext_open = (ctrl_reg[15:8] == `WSDC_EXT_RESET_FN)
    && !ext_reset_nc && ext_q_reg;
  assign do_reset = (prog_mode && all3) || ext_open;

  assign wr_idx = pwdata[3:0];
  assign wr_cnt = pwdata[17:4];
  assign wr_off = pwdata[24:18];
  // a refused load leaves the step table untouched, with no error
  assign step_wr = wr && hit_wr && prog_mode && btn_enter
    && (wr_cnt <= `WSDC_MAX_COUNT);

  // one decode feeds both the write strobes and the error flag
  always_comb begin
    hit_ctrl = 1'b0;
    hit_cfg = 1'b0;
    hit_wr = 1'b0;
    hit_stat = 1'b0;
    hit_ist = 1'b0;
    hit_imask = 1'b0;
    case (paddr)
      `WSDC_OFF_CTRL: hit_ctrl = 1'b1;
      `WSDC_OFF_STEP_CFG: hit_cfg = 1'b1;
      `WSDC_OFF_STEP_WR: hit_wr = 1'b1;
      `WSDC_OFF_STATUS: hit_stat = 1'b1;
      `WSDC_OFF_IRQ_STAT: hit_ist = 1'b1;
      `WSDC_OFF_IRQ_MASK: hit_imask = 1'b1;
      default: hit_ctrl = 1'b0;
    endcase
  end
  assign rd_ok = hit_ctrl || hit_cfg || hit_wr || hit_stat || hit_ist
    || hit_imask;
  assign pslverr = psel && penable && !rd_ok;

  // ----------------------------------------------------------------
  // step table
  // ----------------------------------------------------------------
  // one entry per step, loaded only through the guarded step port
  genvar gi;
  generate
    for (gi = 0; gi < `WSDC_NUM_STEPS; gi++) begin : g_step
      logic hit;
      assign hit = step_wr && (wr_idx == 4'(gi));
      assign step_cnt_next[gi] = hit ? wr_cnt : step_cnt_reg[gi];
      assign step_off_next[gi] = hit ? wr_off : step_off_reg[gi];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          step_cnt_reg[gi] <= 14'h0;
          step_off_reg[gi] <= 7'h0;
        end else begin
          step_cnt_reg[gi] <= step_cnt_next[gi];
          step_off_reg[gi] <= step_off_next[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // counter sequence
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    step_next = step_reg;
    show_next = show_reg;
    disp_next = disp_reg;
    dstep_next = dstep_reg;
    dval_next = dval_reg;
    ev = '0;
    if (do_reset && active) begin
      // reload first step and show it
      step_next = 4'h0;
      cnt_next = step_cnt_reg[0];
      disp_next = step_cnt_reg[0];
      dstep_next = 4'h0;
      dval_next = 1'b1;
      show_next = 8'(`WSDC_SHOW_CYC);
      st_next = WSDC_SHOW;
      ev[`WSDC_IRQ_RESET] = 1'b1;
    end else begin
      case (st_reg)
        WSDC_IDLE: begin
          if (active) begin
            st_next = WSDC_COUNT;
          end
        end
        WSDC_SHOW: begin
          if (show_reg <= 8'h1) begin
            dval_next = 1'b0;
            st_next = active ? WSDC_COUNT : WSDC_IDLE;
          end
          show_next = show_reg - 8'h1;
        end
        WSDC_COUNT: begin
          if (!active) begin
            st_next = WSDC_IDLE;
          end else if (weld_done) begin
            if (cnt_reg > 14'h1) begin
              cnt_next = cnt_reg - 14'h1;
            end else if ({1'b0, step_reg} != last_step) begin
              step_next = nxt_idx;
              cnt_next = step_cnt_reg[nxt_idx];
              ev[`WSDC_IRQ_STEP] = 1'b1;
            end else if (next_empty) begin
              step_next = 4'h0;
              cnt_next = step_cnt_reg[0];
              ev[`WSDC_IRQ_STEP] = 1'b1;
            end else begin
              cnt_next = 14'h0;
              st_next = WSDC_FLASH;
              ev[`WSDC_IRQ_END] = 1'b1;
            end
          end
          if (seq_end && ctrl_reg[18]) begin
            disp_next = cnt_next;
            dstep_next = step_next;
            dval_next = 1'b1;
          end
        end
        WSDC_FLASH: begin
          if (btn_rise || estop) begin
            st_next = WSDC_COUNT;
          end
        end
        default: st_next = WSDC_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // apb and interrupts
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_next = ctrl_reg;
    imask_next = imask_reg;
    ist_next = ist_reg;
    if (wr && hit_ctrl) begin
      ctrl_next = pwdata;
    end
    if (wr && hit_imask) begin
      imask_next = pwdata[`WSDC_IRQ_BITS-1:0];
    end
    if (wr && hit_ist) begin
      ist_next = ist_next & ~pwdata[`WSDC_IRQ_BITS-1:0];
    end
    // set wins over clear
    ist_next = ist_next | ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= 32'h0;
      ist_reg <= '0;
      imask_reg <= '0;
    end else begin
      ctrl_reg <= ctrl_next;
      ist_reg <= ist_next;
      imask_reg <= imask_next;
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // the write-only step port reads as zero
  always_comb begin
    prdata = 32'h0;
    case (paddr)
      `WSDC_OFF_CTRL: prdata = ctrl_reg;
      `WSDC_OFF_STEP_CFG: prdata = {14'h0, cnt_reg, step_reg};
      `WSDC_OFF_STATUS: prdata = {28'h0, st_reg};
      `WSDC_OFF_IRQ_STAT: prdata = {29'h0, ist_reg};
      `WSDC_OFF_IRQ_MASK: prdata = {29'h0, imask_reg};
      default: prdata = 32'h0;
    endcase
  end

  // ----------------------------------------------------------------
  // sequence registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 14'h0;
      step_reg <= 4'h0;
      st_reg <= WSDC_IDLE;
      show_reg <= 8'h0;
      disp_reg <= 14'h0;
      dstep_reg <= 4'h0;
      dval_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      step_reg <= step_next;
      st_reg <= st_next;
      show_reg <= show_next;
      disp_reg <= disp_next;
      dstep_reg <= dstep_next;
      dval_reg <= dval_next;
    end
  end

  // ----------------------------------------------------------------
  // input edges
  // ----------------------------------------------------------------
  // history starts at the idle pin levels, so reset makes no edge
  always_comb begin
    ext_q_next = ext_reset_nc;
    btn_q_next = any_btn;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_q_reg <= 1'b1;
      btn_q_reg <= 1'b0;
    end else begin
      ext_q_reg <= ext_q_next;
      btn_q_reg <= btn_q_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign disp_data = disp_reg;
  assign disp_step = dstep_reg;
  assign disp_valid = dval_reg;
  assign end_flash = (st_reg == WSDC_FLASH);
  assign po_valve = end_flash && (ctrl_reg[17:16] == `WSDC_PO_VALVE);
  assign valve3 = end_flash && (ctrl_reg[17:16] == `WSDC_PO_VALVE3);
  assign irq = |(ist_reg & imask_reg);

endmodule

// >>> inc/wsdc_defines.svh
// offsets, field positions, field codes and timing counts of the step counter
`ifndef WSDC_DEFINES_SVH
`define WSDC_DEFINES_SVH

`define WSDC_OFF_CTRL 12'h000
`define WSDC_OFF_STEP_CFG 12'h004
`define WSDC_OFF_STEP_WR 12'h008
`define WSDC_OFF_STATUS 12'h00c
`define WSDC_OFF_IRQ_STAT 12'h010
`define WSDC_OFF_IRQ_MASK 12'h014

`define WSDC_MAX_COUNT 14'd9999
`define WSDC_NUM_STEPS 16
`define WSDC_SEQ_OFF 2'd0
`define WSDC_SEQ_A 2'd1
`define WSDC_SEQ_B 2'd2
`define WSDC_EXT_RESET_FN 8'h0f
`define WSDC_PO_VALVE 2'd2
`define WSDC_PO_VALVE3 2'd3
`define WSDC_EMPTY_OFF 7'd99
`define WSDC_SHOW_NS 20
`define WSDC_SHOW_CYC ((`WSDC_SHOW_NS + 9) / 10)

`define WSDC_IRQ_END 0
`define WSDC_IRQ_RESET 1
`define WSDC_IRQ_STEP 2
`define WSDC_IRQ_BITS 3

`endif

// >>> inc/wsdc_pkg.sv
// types of the weld-step down-counter
package wsdc_pkg;
  typedef enum logic [3:0] {
    WSDC_IDLE = 4'b0001,
    WSDC_COUNT = 4'b0010,
    WSDC_FLASH = 4'b0100,
    WSDC_SHOW = 4'b1000
  } wsdc_state_e;
  typedef logic [13:0] wsdc_count_t;
endpackage

// >>> test/wsdc_panel.sv
// front panel push buttons and external reset switch
module wsdc_panel (
  input wire logic pclk,
  output logic btn_enter,
  output logic btn_data1,
  output logic btn_data10,
  output logic btn_other,
  output logic estop,
  output logic ext_reset_nc
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {estop, btn_other, btn_data10, btn_data1, btn_enter} = 5'h00;
  initial ext_reset_nc = 1'b1;
  // bit 5 opens the switch, so it is inverted on the pin
  task automatic set_keys(input logic [5:0] v);
    @(posedge pclk);
    {ext_reset_nc, estop, btn_other, btn_data10, btn_data1, btn_enter} <=
      v ^ 6'h20;
  endtask
endmodule

// >>> test/wsdc_counter_sva.sv
// port assertions of the step counter
module wsdc_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic btn_enter,
  input wire logic btn_data1,
  input wire logic btn_data10,
  input wire logic btn_other,
  input wire logic estop,
  input wire logic ext_reset_nc,
  input wire logic weld_done,
  input wire logic end_flash,
  input wire logic po_valve,
  input wire logic valve3
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic any_btn = btn_enter | btn_data1 | btn_data10 | btn_other | estop;
  wire logic any_in = any_btn | !ext_reset_nc;
  a_ready_now: assert property (psel && penable |-> pready)
    else $error("access without ready");
  a_err_unmapped: assert property (psel && penable && paddr > 12'h014
    |-> pslverr && (pwrite || prdata == 32'h0)) else $error("bad unmapped");
  a_valve_flash: assert property (po_valve |-> end_flash)
    else $error("valve without message");
  a_valve3_flash: assert property (valve3 |-> end_flash)
    else $error("valve3 without message");
  a_flash_clear: assert property (end_flash && $rose(any_btn)
    |-> ##[1:2] !end_flash) else $error("message not cleared");
  a_flash_hold: assert property (end_flash && !any_in |=> end_flash)
    else $error("message dropped");
  a_flash_cause: assert property ($rose(end_flash) |-> $past(weld_done))
    else $error("message without weld");
  a_valve_gone: assert property ($fell(end_flash)
    |-> !po_valve && !valve3) else $error("valve left on");
  cover property ($rose(end_flash));
  cover property ($fell(end_flash));
  cover property (psel && penable && pslverr);
endmodule

bind wsdc_counter wsdc_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .btn_enter, .btn_data1, .btn_data10,
  .btn_other, .estop, .ext_reset_nc, .weld_done, .end_flash, .po_valve,
  .valve3);

// >>> test/tb_top.sv
// self-checking bench of the step counter
`include "wsdc_defines.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, prog_mode, weld_done, seq_end;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [13:0] disp_data;
  logic [3:0] disp_step;
  logic disp_valid;
  logic pready, pslverr, end_flash, po_valve, valve3, irq;
  wire logic btn_enter, btn_data1, btn_data10, btn_other, estop, ext_reset_nc;
  int error_cnt = 0;
  int cmp_count = 0;
  wsdc_counter i_wsdc_counter (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .prog_mode, .btn_enter,
    .btn_data1, .btn_data10, .btn_other, .estop, .ext_reset_nc, .weld_done,
    .seq_end, .disp_data, .disp_step, .disp_valid, .end_flash, .po_valve,
    .valve3, .irq);
  wsdc_panel i_wsdc_panel (.pclk, .btn_enter, .btn_data1, .btn_data10,
    .btn_other, .estop, .ext_reset_nc);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic give_verdict();
    $display("compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  // no wait count assumed: hold until pready, watchdog ends a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e, string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask
  task automatic weld(input int n, input logic se);
    repeat (n) begin
      @(posedge pclk);
      weld_done <= 1'b1;
      @(posedge pclk);
      weld_done <= 1'b0;
    end
    // se raises seq_end for one cycle after the last weld pulse
    seq_end <= se;
    @(posedge pclk);
    seq_end <= 1'b0;
  endtask
  function automatic logic [31:0] ctrl(input logic [1:0] po);
    return {8'h0, 5'd1, 1'b1, po, `WSDC_EXT_RESET_FN, 6'd0, `WSDC_SEQ_A};
  endfunction
  initial begin
    repeat (4000) @(posedge pclk);
    error_cnt++;
    give_verdict();
  end
  initial begin
    {psel, penable, pwrite, weld_done, seq_end, prog_mode} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    prog_mode <= 1'b1;
    apb(1'b1, `WSDC_OFF_CTRL, ctrl(`WSDC_PO_VALVE));
    i_wsdc_panel.set_keys(6'h01);
    apb(1'b1, `WSDC_OFF_STEP_WR, {7'd0, 14'd3, 4'd0});
    apb(1'b1, `WSDC_OFF_STEP_WR, {7'd0, 14'd2, 4'd1});
    apb(1'b1, `WSDC_OFF_STEP_WR, {7'd0, 14'd0, 4'd2});
    apb(1'b1, `WSDC_OFF_STEP_WR, {7'd0, 14'd10000, 4'd0});
    i_wsdc_panel.set_keys(6'h03);
    rdchk(`WSDC_OFF_STATUS, 32'h2, "status");
    rdchk(12'h018, 32'h0, "unmapped");
    for (int k = 2; k < 4; k++) begin
      apb(1'b1, `WSDC_OFF_CTRL, ctrl(k[1:0]));
      i_wsdc_panel.set_keys(6'h07);
      i_wsdc_panel.set_keys(6'h00);
      @(posedge pclk);
      chk("show valid", disp_valid, 1);
      chk("show count", disp_data, 3);
      chk("show step", disp_step, 0);
      repeat (3) @(posedge pclk);
      rdchk(`WSDC_OFF_STATUS, 32'h2, "status");
      rdchk(`WSDC_OFF_STEP_CFG, {14'd0, 14'd3, 4'd0}, "cfg");
      prog_mode <= 1'b0;
      weld(1, 1'b1);
      repeat (2) @(posedge pclk);
      chk("shown", disp_data, 2);
      chk("shown valid", disp_valid, 1);
      weld(2, 1'b0);
      rdchk(`WSDC_OFF_STEP_CFG, {14'd0, 14'd2, 4'd1}, "cfg");
      weld(2, 1'b0);
      @(posedge pclk);
      chk("flash", end_flash, 1);
      chk("valves", {po_valve, valve3}, k == 2 ? 2'b10 : 2'b01);
      i_wsdc_panel.set_keys(k == 2 ? 6'h08 : 6'h10);
      i_wsdc_panel.set_keys(6'h00);
      @(posedge pclk);
      chk("cleared", {end_flash, po_valve, valve3}, 0);
      prog_mode <= 1'b1;
    end
    rdchk(`WSDC_OFF_IRQ_STAT, 32'h7, "irq stat");
    apb(1'b1, `WSDC_OFF_IRQ_MASK, 32'h1);
    @(posedge pclk);
    chk("irq", irq, 1);
    apb(1'b1, `WSDC_OFF_IRQ_STAT, 32'h7);
    @(posedge pclk);
    chk("irq", irq, 0);
    i_wsdc_panel.set_keys(6'h01);
    apb(1'b1, `WSDC_OFF_STEP_WR, {`WSDC_EMPTY_OFF, 14'd0, 4'd2});
    i_wsdc_panel.set_keys(6'h20);
    i_wsdc_panel.set_keys(6'h00);
    repeat (4) @(posedge pclk);
    rdchk(`WSDC_OFF_STEP_CFG, {14'd0, 14'd3, 4'd0}, "cfg");
    prog_mode <= 1'b0;
    weld(5, 1'b0);
    @(posedge pclk);
    chk("flash", end_flash, 0);
    rdchk(`WSDC_OFF_STEP_CFG, {14'd0, 14'd3, 4'd0}, "cfg");
    give_verdict();
  end
endmodule
